// [core/tocp_map.svh]
`ifndef TOCP_MAP_SVH
`define TOCP_MAP_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define TOCP_A_CTRL1   8'h00
`define TOCP_A_CTRL2   8'h04
`define TOCP_A_STATUS  8'h08
`define TOCP_A_CMP1_HI 8'h0C
`define TOCP_A_CMP1_LO 8'h10
`define TOCP_A_CMP2_HI 8'h14
`define TOCP_A_CMP2_LO 8'h18
`define TOCP_A_CNT_HI  8'h1C
`define TOCP_A_CNT_LO  8'h20
`define TOCP_A_ALT_HI  8'h24
`define TOCP_A_ALT_LO  8'h28
`define TOCP_A_CAP1_HI 8'h2C
`define TOCP_A_CAP1_LO 8'h30
`define TOCP_A_CAP2_HI 8'h34
`define TOCP_A_CAP2_LO 8'h38

// ----------------------------------------
// Control one bits
// ----------------------------------------
`define TOCP_C1_CAP_IRQ 7
`define TOCP_C1_CMP_IRQ 6
`define TOCP_C1_FORCE2  4
`define TOCP_C1_FORCE1  3
`define TOCP_C1_LVL2    2
`define TOCP_C1_EDGE1   1
`define TOCP_C1_LVL1    0
`define TOCP_C1_WMASK   8'hE7

// ----------------------------------------
// Control two bits
// ----------------------------------------
`define TOCP_C2_PIN1    7
`define TOCP_C2_PIN2    6
`define TOCP_C2_SHOT    5
`define TOCP_C2_PWM     4
`define TOCP_C2_CLK_H   3
`define TOCP_C2_CLK_L   2
`define TOCP_C2_XEDGE   1
`define TOCP_C2_EDGE2   0

// ----------------------------------------
// Clock select codes, reset values and the one-pulse capture value
// ----------------------------------------
`define TOCP_CLK_DIV2   2'h0
`define TOCP_CLK_DIV4   2'h1
`define TOCP_CLK_EXT    2'h3
`define TOCP_CMP_RST    16'h8000
`define TOCP_CNT_RST    16'hFFFC
`define TOCP_CAP_SHOT   16'hFFFD

`endif

// [core/tocp_pkg.sv]
`default_nettype none

package tocp_pkg;

    // Per-channel bus strobes, one cycle each
    typedef struct packed {
        logic wr_hi;
        logic wr_lo;
        logic acc_lo;
        logic st_rd;
    } tocp_chan_ctl_t;

    // Output side of a two-way pin
    typedef struct packed {
        logic o;
        logic oe;
    } tocp_pin_t;

endpackage : tocp_pkg

`default_nettype wire

// [core/tocp_chan.sv]
`include "tocp_map.svh"
`default_nettype none

module tocp_chan (
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire tocp_pkg::tocp_chan_ctl_t ctl,
    input  wire logic [7:0]               wdata,
    input  wire logic [15:0]              cnt_d,
    input  wire logic                     tick,
    input  wire logic                     plus_one,
    input  wire logic                     flag_en,
    output logic [15:0]                   value,
    output logic                          flag,
    output logic                          match
);

    logic [15:0] val_q, val_d;
    logic        inh_q, inh_d;
    logic        arm_q, arm_d;
    logic        flg_q, flg_d;

    // ----------------------------------------
    // Match detect
    // ----------------------------------------
    // Checked on the counter's next value so the event lands on the tick
    assign match = tick && !inh_q
                   && (cnt_d == (plus_one ? val_q + 16'h0001 : val_q));
    assign value = val_q;
    assign flag  = flg_q;

    always_comb begin
        val_d = val_q;
        inh_d = inh_q;
        arm_d = arm_q;
        flg_d = flg_q;
        if (ctl.wr_hi) begin
            val_d[15:8] = wdata;
            inh_d       = 1'h1;
        end
        if (ctl.wr_lo) begin
            val_d[7:0] = wdata;
            inh_d      = 1'h0;
        end
        if (ctl.st_rd && flg_q) begin
            arm_d = 1'h1;
        end
        if (ctl.acc_lo && arm_q) begin
            flg_d = 1'h0;
            arm_d = 1'h0;
        end
        // Set after clear: an event in the clearing cycle survives
        if (match && flag_en) begin
            flg_d = 1'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            val_q <= `TOCP_CMP_RST;
            inh_q <= 1'h0;
            arm_q <= 1'h0;
            flg_q <= 1'h0;
        end else begin
            val_q <= val_d;
            inh_q <= inh_d;
            arm_q <= arm_d;
            flg_q <= flg_d;
        end
    end

endmodule : tocp_chan

`default_nettype wire

// [core/tocp_top.sv]
// Implementation choices: the address map and the APB slave port.
`include "tocp_map.svh"
`default_nettype none

//
// Overview of operation
// - Each timer tick, both compare values are checked against the counter.
// - Compare values are software read/write, untouched by hardware, reset to 8000h.
// - A match sets the channel flag and, if pin enabled, drives its level.
// - Match interrupt needs compare irq enable set and cpu mask clear.
// - Flag clears after status read with flag set, then low byte access.
// - Writing the high byte suppresses compares until the low byte is written.
// - Pin enable clear: pin stays general I/O, interrupt still possible.
// - Divide-by-2 matches at equal count; other clocks at compare plus one.
// - Forced-level bit copies the level to the pin, no flag, no interrupt.
// - Forced-level bits do nothing in one-pulse or PWM mode.
// - One-pulse mode is a control-two bit using capture one and compare one.
// - One-pulse trigger: counter FFFCh, pulse level out, capture flag, FFFDh.
// - One-pulse: compare one match drives the after-pulse level.
// - One-pulse trigger flag requests interrupt when capture irq enabled.
// - One-pulse: compare flag one never set; flag two still works.
// - PWM and one-pulse both set: only PWM operates.
// - Equal pulse and after-pulse levels give a constant pin at that level.
// - One-pulse: capture one does no captures; capture two still does.
// - One-pulse: compare two flags time but drives no pin level.
// - Clock select 11 picks external clock, else cpu clock over 2, 4, 8.
// - Writing counter low or alternate counter low resets counter to FFFCh.
module tocp_top (
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output logic [31:0]             prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire logic               cpu_irq_mask,
    input  wire logic               ext_clock_in,
    input  wire logic               capture_input_one,
    input  wire logic               capture_input_two,
    output tocp_pkg::tocp_pin_t     compare_pin_one,
    output tocp_pkg::tocp_pin_t     compare_pin_two,
    output logic                    timer_irq
);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic edge_of(input logic prev, input logic cur,
                                     input logic rise);
        edge_of = rise ? (!prev && cur) : (prev && !cur);
    endfunction : edge_of

    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a[1:0] == 2'h0) && (a <= `TOCP_A_CAP2_LO);
    endfunction : is_mapped

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    logic       acc;
    logic       wr;
    logic       rd;
    logic [7:0] wb;

    assign acc     = psel && penable;
    assign wr      = acc && pwrite && is_mapped(paddr);
    assign rd      = acc && !pwrite && is_mapped(paddr);
    assign wb      = pwdata[7:0];
    assign pready  = 1'h1;
    assign pslverr = acc && !is_mapped(paddr);

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    // Bit 0 capture one, bit 1 capture two, bit 2 external clock
    logic [2:0] s1_q, s2_q, s3_q, flt_q, fltp_q;
    logic [2:0] flt_d;

    // A level is accepted only once stages two and three agree
    assign flt_d = (s2_q & s3_q) | (flt_q & (s2_q ^ s3_q)) | (s2_q & ~(s2_q ^ s3_q));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q   <= 3'h0;
            s2_q   <= 3'h0;
            s3_q   <= 3'h0;
            flt_q  <= 3'h0;
            fltp_q <= 3'h0;
        end else begin
            s1_q   <= {ext_clock_in, capture_input_two, capture_input_one};
            s2_q   <= s1_q;
            s3_q   <= s2_q;
            flt_q  <= flt_d;
            fltp_q <= flt_q;
        end
    end

    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    logic [7:0] ctl1_q, ctl1_d;
    logic [7:0] ctl2_q, ctl2_d;
    logic       shot_act;
    logic       pwm;
    logic       force1;
    logic       force2;
    logic [1:0] clk_sel;

    assign pwm     = ctl2_q[`TOCP_C2_PWM];
    assign shot_act = ctl2_q[`TOCP_C2_SHOT] && !pwm;
    assign clk_sel = ctl2_q[`TOCP_C2_CLK_H:`TOCP_C2_CLK_L];
    // Forced bits act on the write itself and are not stored
    assign force1  = wr && (paddr == `TOCP_A_CTRL1) && wb[`TOCP_C1_FORCE1]
                     && !pwm && !shot_act;
    assign force2  = wr && (paddr == `TOCP_A_CTRL1) && wb[`TOCP_C1_FORCE2]
                     && !pwm && !shot_act;

    always_comb begin
        ctl1_d = ctl1_q;
        ctl2_d = ctl2_q;
        if (wr && (paddr == `TOCP_A_CTRL1)) begin
            ctl1_d = wb & `TOCP_C1_WMASK;
        end
        if (wr && (paddr == `TOCP_A_CTRL2)) begin
            ctl2_d = wb;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl1_q <= 8'h00;
            ctl2_q <= 8'h00;
        end else begin
            ctl1_q <= ctl1_d;
            ctl2_q <= ctl2_d;
        end
    end

    // ----------------------------------------
    // Timer clock and counter
    // ----------------------------------------
    logic [2:0]  pre_q, pre_d;
    logic [15:0] cnt_q, cnt_d;
    logic        tick;
    logic        ext_edge;
    logic        edge1;
    logic        edge2;
    logic        trig;

    assign ext_edge = edge_of(fltp_q[2], flt_q[2], ctl2_q[`TOCP_C2_XEDGE]);
    assign edge1    = edge_of(fltp_q[0], flt_q[0], ctl1_q[`TOCP_C1_EDGE1]);
    assign edge2    = edge_of(fltp_q[1], flt_q[1], ctl2_q[`TOCP_C2_EDGE2]);
    assign trig     = shot_act && edge1;

    always_comb begin
        pre_d = pre_q + 3'h1;
        case (clk_sel)
            `TOCP_CLK_DIV2: tick = (pre_q[0] == 1'h1);
            `TOCP_CLK_DIV4: tick = (pre_q[1:0] == 2'h3);
            `TOCP_CLK_EXT:  tick = ext_edge;
            default:        tick = (pre_q == 3'h7);
        endcase
        cnt_d = cnt_q;
        if (tick) begin
            cnt_d = cnt_q + 16'h0001;
        end
        if (trig || (wr && ((paddr == `TOCP_A_CNT_LO) || (paddr == `TOCP_A_ALT_LO)))) begin
            cnt_d = `TOCP_CNT_RST;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_q <= 3'h0;
            cnt_q <= `TOCP_CNT_RST;
        end else begin
            pre_q <= pre_d;
            cnt_q <= cnt_d;
        end
    end

    // ----------------------------------------
    // Compare channels
    // ----------------------------------------
    tocp_pkg::tocp_chan_ctl_t c1_ctl;
    tocp_pkg::tocp_chan_ctl_t c2_ctl;
    logic [15:0] cmp1;
    logic [15:0] cmp2;
    logic        cf1;
    logic        cf2;
    logic        m1;
    logic        m2;
    logic        st_rd;
    logic        plus_one;

    assign st_rd    = rd && (paddr == `TOCP_A_STATUS);
    assign plus_one = (clk_sel != `TOCP_CLK_DIV2);

    always_comb begin
        c1_ctl.wr_hi  = wr && (paddr == `TOCP_A_CMP1_HI);
        c1_ctl.wr_lo  = wr && (paddr == `TOCP_A_CMP1_LO);
        c1_ctl.acc_lo = (wr || rd) && (paddr == `TOCP_A_CMP1_LO);
        c1_ctl.st_rd  = st_rd;
        c2_ctl.wr_hi  = wr && (paddr == `TOCP_A_CMP2_HI);
        c2_ctl.wr_lo  = wr && (paddr == `TOCP_A_CMP2_LO);
        c2_ctl.acc_lo = (wr || rd) && (paddr == `TOCP_A_CMP2_LO);
        c2_ctl.st_rd  = st_rd;
    end

    // Two identical channels on one counter
    tocp_chan u_chan_one (
        .pclk     (pclk),
        .presetn  (presetn),
        .ctl      (c1_ctl),
        .wdata    (wb),
        .cnt_d    (cnt_d),
        .tick     (tick),
        .plus_one (plus_one),
        .flag_en  (!pwm && !shot_act),
        .value    (cmp1),
        .flag     (cf1),
        .match    (m1)
    );

    tocp_chan u_chan_two (
        .pclk     (pclk),
        .presetn  (presetn),
        .ctl      (c2_ctl),
        .wdata    (wb),
        .cnt_d    (cnt_d),
        .tick     (tick),
        .plus_one (plus_one),
        .flag_en  (!pwm),
        .value    (cmp2),
        .flag     (cf2),
        .match    (m2)
    );

    // ----------------------------------------
    // Compare pins
    // ----------------------------------------
    logic pin1_q, pin1_d;
    logic pin2_q, pin2_d;
    logic en1;
    logic en2;

    assign en1 = ctl2_q[`TOCP_C2_PIN1];
    assign en2 = ctl2_q[`TOCP_C2_PIN2];

    always_comb begin
        pin1_d = pin1_q;
        pin2_d = pin2_q;
        if (shot_act) begin
            // Equal levels simply hold the pin at that one level
            if (trig) begin
                pin1_d = ctl1_q[`TOCP_C1_LVL2];
            end else if (m1) begin
                pin1_d = ctl1_q[`TOCP_C1_LVL1];
            end
        end else if (!pwm) begin
            if (m1 && en1) begin
                pin1_d = ctl1_q[`TOCP_C1_LVL1];
            end
            if (m2 && en2) begin
                pin2_d = ctl1_q[`TOCP_C1_LVL2];
            end
        end
        if (force1 && en1) begin
            pin1_d = wb[`TOCP_C1_LVL1];
        end
        if (force2 && en2) begin
            pin2_d = wb[`TOCP_C1_LVL2];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin1_q <= 1'h0;
            pin2_q <= 1'h0;
        end else begin
            pin1_q <= pin1_d;
            pin2_q <= pin2_d;
        end
    end

    assign compare_pin_one.o  = pin1_q;
    assign compare_pin_one.oe = en1;
    assign compare_pin_two.o  = pin2_q;
    assign compare_pin_two.oe = en2;

    // ----------------------------------------
    // Capture flags and values
    // ----------------------------------------
    logic [15:0] cap1_q, cap1_d;
    logic [15:0] cap2_q, cap2_d;
    logic        kf1_q, kf1_d, ka1_q, ka1_d;
    logic        kf2_q, kf2_d, ka2_q, ka2_d;
    logic        cap1_acc;
    logic        cap2_acc;

    assign cap1_acc = (wr || rd) && (paddr == `TOCP_A_CAP1_LO);
    assign cap2_acc = (wr || rd) && (paddr == `TOCP_A_CAP2_LO);

    always_comb begin
        cap1_d = cap1_q;
        cap2_d = cap2_q;
        kf1_d  = kf1_q;
        ka1_d  = ka1_q;
        kf2_d  = kf2_q;
        ka2_d  = ka2_q;
        if (st_rd && kf1_q) begin
            ka1_d = 1'h1;
        end
        if (st_rd && kf2_q) begin
            ka2_d = 1'h1;
        end
        if (cap1_acc && ka1_q) begin
            kf1_d = 1'h0;
            ka1_d = 1'h0;
        end
        if (cap2_acc && ka2_q) begin
            kf2_d = 1'h0;
            ka2_d = 1'h0;
        end
        if (trig) begin
            kf1_d  = 1'h1;
            cap1_d = `TOCP_CAP_SHOT;
        end else if (edge1 && !pwm && !ctl2_q[`TOCP_C2_SHOT]) begin
            kf1_d  = 1'h1;
            cap1_d = cnt_q;
        end
        if (edge2) begin
            kf2_d  = 1'h1;
            cap2_d = cnt_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap1_q <= 16'h0000;
            cap2_q <= 16'h0000;
            kf1_q  <= 1'h0;
            ka1_q  <= 1'h0;
            kf2_q  <= 1'h0;
            ka2_q  <= 1'h0;
        end else begin
            cap1_q <= cap1_d;
            cap2_q <= cap2_d;
            kf1_q  <= kf1_d;
            ka1_q  <= ka1_d;
            kf2_q  <= kf2_d;
            ka2_q  <= ka2_d;
        end
    end

    // ----------------------------------------
    // Interrupt request
    // ----------------------------------------
    assign timer_irq = !cpu_irq_mask
                       && ((ctl1_q[`TOCP_C1_CMP_IRQ] && (cf1 || cf2))
                           || (ctl1_q[`TOCP_C1_CAP_IRQ] && (kf1_q || kf2_q)));

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    // Sampled in the setup cycle, so read data is a flop at the access edge
    logic [7:0]  rmux;
    logic [31:0] prdata_q, prdata_d;

    always_comb begin
        case (paddr)
            `TOCP_A_CTRL1:   rmux = ctl1_q;
            `TOCP_A_CTRL2:   rmux = ctl2_q;
            `TOCP_A_STATUS:  rmux = {kf1_q, cf1, 1'h0, kf2_q, cf2, 3'h0};
            `TOCP_A_CMP1_HI: rmux = cmp1[15:8];
            `TOCP_A_CMP1_LO: rmux = cmp1[7:0];
            `TOCP_A_CMP2_HI: rmux = cmp2[15:8];
            `TOCP_A_CMP2_LO: rmux = cmp2[7:0];
            `TOCP_A_CNT_HI:  rmux = cnt_q[15:8];
            `TOCP_A_CNT_LO:  rmux = cnt_q[7:0];
            `TOCP_A_ALT_HI:  rmux = cnt_q[15:8];
            `TOCP_A_ALT_LO:  rmux = cnt_q[7:0];
            `TOCP_A_CAP1_HI: rmux = cap1_q[15:8];
            `TOCP_A_CAP1_LO: rmux = cap1_q[7:0];
            `TOCP_A_CAP2_HI: rmux = cap2_q[15:8];
            `TOCP_A_CAP2_LO: rmux = cap2_q[7:0];
            default:         rmux = 8'h00;
        endcase
        prdata_d = prdata_q;
        if (psel && !penable) begin
            prdata_d = {24'h000000, rmux};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h00000000;
        end else begin
            prdata_q <= prdata_d;
        end
    end

    assign prdata = prdata_q;

endmodule : tocp_top

`default_nettype wire

// [verification/tocp_chk_sva.sv]
`include "tocp_map.svh"
`default_nettype none

module tocp_chk (
    input wire logic                pclk,
    input wire logic                presetn,
    input wire logic                psel,
    input wire logic                penable,
    input wire logic                pwrite,
    input wire logic [7:0]          paddr,
    input wire logic [31:0]         pwdata,
    input wire logic [31:0]         prdata,
    input wire logic                pready,
    input wire logic                pslverr,
    input wire logic                cpu_irq_mask,
    input wire tocp_pkg::tocp_pin_t compare_pin_one,
    input wire tocp_pkg::tocp_pin_t compare_pin_two,
    input wire logic                timer_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----
    // Mode shadow
    // ----
    logic      shot_q;
    logic      pwm_q;
    wire logic ctl2_wr = psel && penable && pwrite && paddr == `TOCP_A_CTRL2;
    wire logic mapped  = paddr <= 8'h38 && paddr[1:0] == 2'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shot_q <= 1'h0;
            pwm_q <= 1'h0;
        end else if (ctl2_wr) begin
            shot_q <= pwdata[`TOCP_C2_SHOT];
            pwm_q <= pwdata[`TOCP_C2_PWM];
        end
    end

    // ----
    // Properties
    // ----
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence acc_s;
        psel && penable;
    endsequence
    sequence wr1_s;
        acc_s ##0 pwrite && paddr == `TOCP_A_CTRL1;
    endsequence

    ready_high_a: assert property (pready) else $error("pready low");
    bad_addr_a: assert property (acc_s ##0 !mapped |-> pslverr) else $error("no slverr");
    good_addr_a: assert property (acc_s ##0 mapped |-> !pslverr) else $error("slverr set");
    idle_err_a: assert property (!(psel && penable) |-> !pslverr) else $error("slverr idle");
    rdata_top_a: assert property (acc_s ##0 !pwrite |-> prdata[31:8] == 24'h0)
        else $error("prdata upper set");
    irq_mask_a: assert property (cpu_irq_mask |-> !timer_irq) else $error("irq masked");
    pin_enable_a: assert property (ctl2_wr |=> compare_pin_one.oe == $past(pwdata[7])
        && compare_pin_two.oe == $past(pwdata[6])) else $error("pin enable");
    oe_hold_a: assert property (!ctl2_wr |=> $stable(compare_pin_one.oe))
        else $error("oe moved");
    force_level_a: assert property (wr1_s ##0 pwdata[3] && compare_pin_one.oe
        && !shot_q && !pwm_q |=> compare_pin_one.o == $past(pwdata[0])) else $error("force");
    mode_force_a: assert property (wr1_s ##0 (shot_q || pwm_q)
        |=> $stable(compare_pin_one.o) && $stable(compare_pin_two.o)) else $error("forced");
    shot_pin_two_a: assert property (shot_q && !pwm_q |=> $stable(compare_pin_two.o))
        else $error("pin two moved");
endmodule : tocp_chk

bind tocp_top tocp_chk chk_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cpu_irq_mask(cpu_irq_mask), .compare_pin_one(compare_pin_one),
    .compare_pin_two(compare_pin_two), .timer_irq(timer_irq)
);

`default_nettype wire

// [verification/tocp_pin_model.sv]
`default_nettype none

module tocp_pin_model (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic fire,
    output logic      ext_clock_in,
    output logic      capture_input_one,
    output logic      capture_input_two
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] div_q;

    // ----
    // Pin drivers
    // ----
    // External clock runs free at a tenth of pclk, under the quarter limit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q             <= 3'h0;
            ext_clock_in      <= 1'h0;
            capture_input_one <= 1'h0;
            capture_input_two <= 1'h0;
        end else begin
            div_q             <= (div_q == 3'h4) ? 3'h0 : div_q + 3'h1;
            ext_clock_in      <= (div_q == 3'h4) ? !ext_clock_in : ext_clock_in;
            capture_input_one <= fire;
            capture_input_two <= fire;
        end
    end
endmodule : tocp_pin_model

`default_nettype wire

// [verification/timer_output_compare_one_pulse_tb_top.sv]
`include "tocp_map.svh"
`default_nettype none

module timer_output_compare_one_pulse_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic                pclk;
    logic                presetn;
    logic                psel;
    logic                penable;
    logic                pwrite;
    logic                cpu_irq_mask;
    logic                fire;
    logic                ext_clk;
    logic                cap_one;
    logic                cap_two;
    logic [7:0]          paddr;
    logic [31:0]         pwdata;
    logic [31:0]         prdata;
    logic [31:0]         rd;
    logic                pready;
    logic                pslverr;
    logic                timer_irq;
    tocp_pkg::tocp_pin_t pin_one;
    tocp_pkg::tocp_pin_t pin_two;
    int                  miscompares = 0;
    int                  cmp_count = 0;

    tocp_top dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cpu_irq_mask(cpu_irq_mask), .ext_clock_in(ext_clk), .capture_input_one(cap_one),
        .capture_input_two(cap_two), .compare_pin_one(pin_one), .compare_pin_two(pin_two),
        .timer_irq(timer_irq)
    );
    tocp_pin_model pin_u (
        .pclk(pclk), .presetn(presetn), .fire(fire), .ext_clock_in(ext_clk),
        .capture_input_one(cap_one), .capture_input_two(cap_two)
    );

    // ----
    // Bus and check tasks
    // ----
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'h1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'h1;
        // Wait for pready; only the watchdog ends a hang
        do begin
            @(posedge pclk);
        end while (pready !== 1'h1);
        rd = prdata;
        psel    <= 1'h0;
        penable <= 1'h0;
    endtask : apb
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'h1, a, d);
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'h0, a, 32'h0);
        chk(rd, e);
    endtask : rdc
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask : cyc
    task automatic final_report();
        $display("Comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : final_report

    initial begin
        pclk = 1'h0;
        forever #10 pclk = ~pclk;
    end
    initial begin
        cyc(5000);
        miscompares++;
        final_report();
    end

    // ----
    // Tests
    // ----
    initial begin
        presetn      = 1'h0;
        psel         = 1'h0;
        penable      = 1'h0;
        pwrite       = 1'h0;
        paddr        = 8'h0;
        pwdata       = 32'h0;
        cpu_irq_mask = 1'h1;
        fire         = 1'h0;
        cyc(20);
        presetn <= 1'h1;
        rdc(`TOCP_A_CMP1_HI, 32'h80);
        rdc(`TOCP_A_CMP1_LO, 32'h00);
        rdc(`TOCP_A_CMP2_HI, 32'h80);
        rdc(`TOCP_A_CMP2_LO, 32'h00);
        rdc(8'h3C, 32'h0);
        wr(`TOCP_A_CMP2_HI, 32'hA5);
        wr(`TOCP_A_CMP2_LO, 32'h3C);
        rdc(`TOCP_A_CMP2_HI, 32'hA5);
        rdc(`TOCP_A_CMP2_LO, 32'h3C);
        // Every clock select, level alternating so each match shows on the pin
        for (int s = 0; s < 4; s++) begin
            wr(`TOCP_A_CTRL1, {25'h0, 1'h1, 5'h0, ~s[0]});
            wr(`TOCP_A_CTRL2, {24'h0, 1'h1, 3'h0, s[1:0], 2'h2});
            wr(`TOCP_A_CMP1_HI, 32'h0);
            apb(1'h0, `TOCP_A_STATUS, 32'h0);
            wr(`TOCP_A_CMP1_LO, 32'h08);
            wr(`TOCP_A_CNT_LO, 32'h0);
            cyc(14);
            rdc(`TOCP_A_STATUS, 32'h00);
            cyc(200);
            chk(32'(pin_one.o), 32'(s[0] == 1'h0));
            cpu_irq_mask <= 1'h0;
            rdc(`TOCP_A_STATUS, 32'h40);
            chk(32'(timer_irq), 32'h1);
            cpu_irq_mask <= 1'h1;
            apb(1'h0, `TOCP_A_CMP1_LO, 32'h0);
            rdc(`TOCP_A_STATUS, 32'h00);
        end
        // High byte alone holds the compare off; pin disabled still interrupts
        wr(`TOCP_A_CTRL2, 32'h0);
        wr(`TOCP_A_CMP1_HI, 32'h0);
        wr(`TOCP_A_CNT_LO, 32'h0);
        cyc(60);
        rdc(`TOCP_A_STATUS, 32'h00);
        wr(`TOCP_A_CMP1_LO, 32'h08);
        wr(`TOCP_A_CNT_LO, 32'h0);
        cyc(60);
        cpu_irq_mask <= 1'h0;
        rdc(`TOCP_A_STATUS, 32'h40);
        chk(32'(timer_irq), 32'h1);
        chk(32'(pin_one.oe), 32'h0);
        cpu_irq_mask <= 1'h1;
        apb(1'h0, `TOCP_A_CMP1_LO, 32'h0);
        // Forced levels, then ignored once one-pulse is on
        wr(`TOCP_A_CTRL2, 32'h80);
        wr(`TOCP_A_CTRL1, 32'h09);
        cyc(2);
        chk(32'(pin_one.o), 32'h1);
        rdc(`TOCP_A_STATUS, 32'h00);
        wr(`TOCP_A_CTRL1, 32'h08);
        cyc(2);
        chk(32'(pin_one.o), 32'h0);
        wr(`TOCP_A_CTRL2, 32'hA0);
        wr(`TOCP_A_CTRL1, 32'h09);
        cyc(2);
        chk(32'(pin_one.o), 32'h0);
        wr(`TOCP_A_CTRL2, 32'hB0);
        wr(`TOCP_A_CTRL1, 32'h09);
        cyc(2);
        chk(32'(pin_one.o), 32'h0);
        // One pulse of 0x24 counts, loaded as counts less four
        wr(`TOCP_A_CTRL2, 32'hE1);
        wr(`TOCP_A_CMP1_HI, 32'h0);
        apb(1'h0, `TOCP_A_STATUS, 32'h0);
        wr(`TOCP_A_CMP1_LO, 32'h20);
        wr(`TOCP_A_CMP2_HI, 32'h0);
        apb(1'h0, `TOCP_A_STATUS, 32'h0);
        wr(`TOCP_A_CMP2_LO, 32'h10);
        wr(`TOCP_A_CTRL1, 32'hC6);
        cpu_irq_mask <= 1'h0;
        fire         <= 1'h1;
        cyc(12);
        chk(32'(pin_one.o), 32'h1);
        chk(32'(timer_irq), 32'h1);
        rdc(`TOCP_A_STATUS, 32'h90);
        rdc(`TOCP_A_CAP1_HI, 32'hFF);
        rdc(`TOCP_A_CAP1_LO, 32'hFD);
        cyc(100);
        chk(32'(pin_one.o), 32'h0);
        chk(32'(pin_two.o), 32'h0);
        apb(1'h0, `TOCP_A_STATUS, 32'h0);
        chk(rd & 32'h48, 32'h08);
        final_report();
    end
endmodule : timer_output_compare_one_pulse_tb_top

`default_nettype wire
